// [rtl/trfe_encoder.sv]
`timescale 1ns/10ps
`include "trfe_defines.svh"


// ----------------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides.
// ----------------------------------------------------------------------------
module trfe_fifo #(
    parameter int W = `TRFE_FIFO_WIDTH,
    parameter int D = `TRFE_FIFO_DEPTH
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   count_q;
    wire           push;
    wire           pop;

    // Full and empty come straight from the fill count.
    assign in_ready  = (count_q != (AW+1)'(D));
    assign out_valid = (count_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // Storage is written only on an accepted push.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap at the depth so any depth works, not only powers of two.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------------
// Transmit rail format selection and B3ZS/HDB3 line encoder.
// ----------------------------------------------------------------------------
module trfe_encoder (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       tx_positive_rail_in,
    input  wire logic       tx_negative_rail_in,
    input  wire logic       tx_rail_valid,
    output logic            tx_rail_ready,
    input  wire logic       rail_format_select_pin,
    input  wire logic       host_mode_pin,
    input  wire logic [1:0] rate_select_pin,
    input  wire logic       host_single_rail_bit,
    output logic            codec_enable_q,
    output logic            line_pos_q,
    output logic            line_neg_q,
    output logic            line_valid_q,
    input  wire logic       line_ready
);
    // ------------------------------------------------------------------------
    // Pin synchronisers; only the second stage is read.
    // ------------------------------------------------------------------------
    logic [`TRFE_SYNC_W-1:0] sync1_q;
    logic [`TRFE_SYNC_W-1:0] sync2_q;
    wire  [`TRFE_SYNC_W-1:0] pins;

    assign pins = {rate_select_pin, host_mode_pin, rail_format_select_pin,
                   tx_rail_valid, tx_positive_rail_in, tx_negative_rail_in};

    // Two flops per pin; reset keeps the rails quiet until they settle.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    wire       s_neg   = sync2_q[0];
    wire       s_pos   = sync2_q[1];
    wire       s_valid = sync2_q[2];
    wire       s_sel   = sync2_q[3];
    wire       s_host  = sync2_q[4];
    wire [1:0] s_rate  = sync2_q[6:5];

    // ------------------------------------------------------------------------
    // Format and code selection.
    // ------------------------------------------------------------------------
    wire single_rail;
    wire hdb3_mode;

    assign single_rail = s_host ? host_single_rail_bit : s_sel;
    assign hdb3_mode   = (s_rate == `TRFE_RATE_E3);

    // ------------------------------------------------------------------------
    // Input buffer between the framer pins and the encoder.
    // ------------------------------------------------------------------------
    trfe_pkg::trfe_rail_t fifo_in;
    trfe_pkg::trfe_rail_t fifo_out;
    logic                 fifo_out_valid;
    wire                  advance;

    assign fifo_in.pos = s_pos;
    assign fifo_in.neg = s_neg;

    trfe_fifo #(
        .W (`TRFE_FIFO_WIDTH),
        .D (`TRFE_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_data   (fifo_in),
        .in_valid  (s_valid),
        .in_ready  (tx_rail_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (advance)
    );

    // The encoder steps only when a bit waits and the line side can take one.
    assign advance = fifo_out_valid && (!line_valid_q || line_ready);

    // ------------------------------------------------------------------------
    // Look-ahead slots; substitution rewrites them before they leave.
    // ------------------------------------------------------------------------
    trfe_pkg::trfe_code_t code_q [`TRFE_SLOTS];
    trfe_pkg::trfe_code_t code_d [`TRFE_SLOTS];
    trfe_pkg::trfe_code_t new_code;
    trfe_pkg::trfe_code_t out_code;
    logic                 parity_q;
    logic                 parity_d;
    logic                 last_pol_q;
    wire                  in_mark;
    wire                  run_b3zs;
    wire                  run_hdb3;
    wire                  subst;

    // Dual rail marks either rail, so a violation pair collapses to one mark.
    assign in_mark  = single_rail ? fifo_out.pos : (fifo_out.pos || fifo_out.neg);
    assign new_code = in_mark ? trfe_pkg::TRFE_MARK : trfe_pkg::TRFE_ZERO;
    assign run_b3zs = !in_mark && code_q[0] == trfe_pkg::TRFE_ZERO
                      && code_q[1] == trfe_pkg::TRFE_ZERO;
    assign run_hdb3 = run_b3zs && code_q[2] == trfe_pkg::TRFE_ZERO;
    assign subst    = single_rail && (hdb3_mode ? run_hdb3 : run_b3zs);
    assign out_code = hdb3_mode ? code_q[3] : code_q[2];

    // Even parity since the last violation needs a leading B to keep it odd.
    always_comb begin
        code_d[0] = subst ? trfe_pkg::TRFE_VIOL : new_code;
        for (int i = 1; i < `TRFE_SLOTS; i++) begin
            code_d[i] = code_q[i-1];
        end
        if (subst && !parity_q) begin
            if (hdb3_mode) begin
                code_d[3] = trfe_pkg::TRFE_MARK;
            end else begin
                code_d[2] = trfe_pkg::TRFE_MARK;
            end
        end
        parity_d = subst ? 1'b0 : (parity_q ^ in_mark);
    end

    // Slot and parity state advance with the data.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            for (int i = 0; i < `TRFE_SLOTS; i++) begin
                code_q[i] <= trfe_pkg::TRFE_ZERO;
            end
            parity_q <= 1'b0;
        end else if (advance) begin
            code_q   <= code_d;
            parity_q <= parity_d;
        end
    end

    // ------------------------------------------------------------------------
    // Polarity assignment and line output register.
    // ------------------------------------------------------------------------
    wire out_b = (out_code == trfe_pkg::TRFE_MARK);
    wire out_v = (out_code == trfe_pkg::TRFE_VIOL);
    wire pulse_pol = out_b ? !last_pol_q : last_pol_q;

    // A violation repeats the last polarity; a mark flips it.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            line_pos_q     <= 1'b0;
            line_neg_q     <= 1'b0;
            line_valid_q   <= 1'b0;
            last_pol_q     <= 1'b0;
            codec_enable_q <= 1'b0;
        end else begin
            codec_enable_q <= single_rail;
            if (advance) begin
                line_pos_q   <= (out_b || out_v) && pulse_pol;
                line_neg_q   <= (out_b || out_v) && !pulse_pol;
                line_valid_q <= 1'b1;
                if (out_b) begin
                    last_pol_q <= !last_pol_q;
                end
            end else if (line_ready) begin
                line_valid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks: helper counters that track line zero runs after a mode settles.
    // ------------------------------------------------------------------------
    logic [2:0] zrun_q;
    logic [2:0] settle_q;
    logic       mode_q;
    logic       rate_q;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            zrun_q   <= 3'h0;
            settle_q <= 3'h0;
            mode_q   <= 1'b0;
            rate_q   <= 1'b0;
        end else begin
            mode_q <= single_rail;
            rate_q <= hdb3_mode;
            if (mode_q != single_rail || rate_q != hdb3_mode) begin
                settle_q <= 3'h0;
            end else if (advance && settle_q != `TRFE_MODE_SETTLE) begin
                settle_q <= settle_q + 3'h1;
            end
            if (advance) begin
                zrun_q <= (out_b || out_v) ? 3'h0 : ((zrun_q == 3'h7) ? zrun_q : zrun_q + 3'h1);
            end
        end
    end

    wire settled = (settle_q == `TRFE_MODE_SETTLE) && (mode_q == single_rail)
                   && (rate_q == hdb3_mode);

    property p_single_sel;
        @(posedge mclk) disable iff (!resetn)
        (!s_host && s_sel) || (s_host && host_single_rail_bit) |=> codec_enable_q;
    endproperty
    a_single_sel: assert property (p_single_sel) else $error("single rail not selected");

    property p_dual_sel;
        @(posedge mclk) disable iff (!resetn)
        (!s_host && !s_sel) || (s_host && !host_single_rail_bit) |=> !codec_enable_q;
    endproperty
    a_dual_sel: assert property (p_dual_sel) else $error("dual rail not selected");

    property p_codec_follow;
        @(posedge mclk) disable iff (!resetn)
        $changed(single_rail) |=> codec_enable_q == $past(single_rail);
    endproperty
    a_codec_follow: assert property (p_codec_follow) else $error("codec enable lags");

    property p_dual_bypass;
        @(posedge mclk) disable iff (!resetn)
        advance && !single_rail |=> code_q[0] != trfe_pkg::TRFE_VIOL;
    endproperty
    a_dual_bypass: assert property (p_dual_bypass) else $error("substitution in dual rail");

    property p_b3zs_run;
        @(posedge mclk) disable iff (!resetn)
        settled && single_rail && !hdb3_mode |-> zrun_q <= `TRFE_B3ZS_MAX_ZERO;
    endproperty
    a_b3zs_run: assert property (p_b3zs_run) else $error("three zeros left B3ZS");

    property p_hdb3_run;
        @(posedge mclk) disable iff (!resetn)
        settled && single_rail && hdb3_mode |-> zrun_q <= `TRFE_HDB3_MAX_ZERO;
    endproperty
    a_hdb3_run: assert property (p_hdb3_run) else $error("four zeros left HDB3");

    property p_dual_no_viol;
        @(posedge mclk) disable iff (!resetn)
        settled && !single_rail && advance |-> !out_v;
    endproperty
    a_dual_no_viol: assert property (p_dual_no_viol) else $error("violation in dual rail");

    property p_ami;
        @(posedge mclk) disable iff (!resetn)
        advance && out_b |=> line_pos_q == !$past(last_pol_q) && line_neg_q == $past(last_pol_q);
    endproperty
    a_ami: assert property (p_ami) else $error("mark polarity not alternated");

    property p_viol_pol;
        @(posedge mclk) disable iff (!resetn)
        advance && out_v |=> line_pos_q == $past(last_pol_q) && line_neg_q != $past(last_pol_q);
    endproperty
    a_viol_pol: assert property (p_viol_pol) else $error("violation polarity wrong");

    c_b3zs_sub: cover property (@(posedge mclk) disable iff (!resetn)
                                subst && !hdb3_mode && !parity_q);
    c_hdb3_sub: cover property (@(posedge mclk) disable iff (!resetn)
                                subst && hdb3_mode && parity_q);
    c_dual_pair: cover property (@(posedge mclk) disable iff (!resetn)
                                 advance && !single_rail && fifo_out.pos && fifo_out.neg);
    c_fifo_full: cover property (@(posedge mclk) disable iff (!resetn) !tx_rail_ready);
endmodule

// [rtl/trfe_defines.svh]
`ifndef TRFE_DEFINES_SVH
`define TRFE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Geometry and codes of the transmit format encoder.
// ----------------------------------------------------------------------------
`define TRFE_FIFO_DEPTH     8
`define TRFE_FIFO_WIDTH     2
`define TRFE_SLOTS          4
`define TRFE_SYNC_W         7
`define TRFE_MODE_SETTLE    3'h5
`define TRFE_RATE_E3        2'h0
`define TRFE_RATE_DS3       2'h1
`define TRFE_RATE_STS1      2'h2
`define TRFE_B3ZS_MAX_ZERO  3'h2
`define TRFE_HDB3_MAX_ZERO  3'h3

`endif

// [rtl/trfe_pkg.sv]
package trfe_pkg;

    // ------------------------------------------------------------------------
    // Types shared by the encoder and its buffer.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic pos;
        logic neg;
    } trfe_rail_t;

    typedef enum logic [1:0] {
        TRFE_ZERO = 2'h0,
        TRFE_MARK = 2'h1,
        TRFE_VIOL = 2'h3
    } trfe_code_t;

endpackage

// [testbench/trfe_framer_model.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Framer model that presents one rail word per bit time.
// ----------------------------------------------------------------------------
module trfe_framer_model (
    input  wire logic mclk,
    input  wire logic single_rail,
    output logic      pos,
    output logic      neg,
    output logic      valid
);
    initial begin
        pos   = 1'h0;
        neg   = 1'h0;
        valid = 1'h0;
    end

    // Released pos flips on every idle cycle, and neg too in dual rail (low in single rail), so stale data never looks valid.
    task automatic idle();
        @(posedge mclk);
        valid <= 1'h0;
        pos   <= ~pos;
        neg   <= single_rail ? 1'h0 : ~neg;
    endtask

    // One word for one edge, then the given number of idle cycles.
    task automatic send(input logic [1:0] w, input int gap);
        @(posedge mclk);
        pos   <= w[1];
        neg   <= single_rail ? 1'h0 : w[0];
        valid <= 1'h1;
        repeat (gap) idle();
    endtask
endmodule

// [testbench/trfe_encoder_tb.sv]
`timescale 1ns/10ps
`include "trfe_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

module trfe_encoder_tb;
    logic       mclk = 1'h0;
    logic       resetn = 1'h0;
    logic       sr = 1'h1;
    logic       rail_pin = 1'h1;
    logic       host_mode = 1'h0;
    logic       host_bit = 1'h0;
    logic       line_ready = 1'h1;
    logic [1:0] rate = 2'h0;
    logic       pos, neg, valid, ready, codec_en, lpos, lneg, lvalid;
    logic [1:0] got[$];
    logic [1:0] sent[$];
    int         n_fail = 0;
    int         n_checks = 0;

    always #20 mclk = ~mclk;

    trfe_framer_model frm (.mclk(mclk), .single_rail(sr), .pos(pos), .neg(neg), .valid(valid));

    trfe_encoder uut (
        .mclk(mclk), .resetn(resetn), .tx_positive_rail_in(pos), .tx_negative_rail_in(neg),
        .tx_rail_valid(valid), .tx_rail_ready(ready), .rail_format_select_pin(rail_pin),
        .host_mode_pin(host_mode), .rate_select_pin(rate), .host_single_rail_bit(host_bit),
        .codec_enable_q(codec_en), .line_pos_q(lpos), .line_neg_q(lneg),
        .line_valid_q(lvalid), .line_ready(line_ready)
    );

    // ------------------------------------------------------------------------
    // Line monitor and closing.
    // ------------------------------------------------------------------------
    // Words are taken where the pulse shaper accepts them; both rails high is never legal.
    always @(posedge mclk) begin
        if (lvalid && line_ready) begin
            got.push_back({lpos, lneg});
            `CHK(lpos & lneg, 1'h0)
        end
    end

    task automatic end_of_test();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------------------
    // Pins are synchronised, so the format is awaited under a bound, not a fixed count.
    task automatic setup(input logic hm, input logic hb, input logic pin, input logic [1:0] r);
        logic ex;
        int   w;
        ex = hm ? hb : pin;
        @(posedge mclk);
        host_mode <= hm;
        host_bit  <= hb;
        rail_pin  <= pin;
        rate      <= r;
        sr        <= ex;
        resetn    <= 1'h0;
        repeat (3) @(posedge mclk);
        resetn <= 1'h1;
        w = 0;
        do begin
            @(negedge mclk);
            w++;
        end while (codec_en !== ex && w < 12);
        `CHK(codec_en, ex)
        got.delete();
        sent.delete();
    endtask

    task automatic push(input logic [1:0] w, input int gap);
        sent.push_back(w);
        frm.send(w, gap);
    endtask

    // Pads with spaces, since trailing bits wait in the look-ahead slots.
    task automatic check_out(input int n);
        logic [1:0] e[$];
        logic       lp, par;
        int         z, k, w;
        k = (rate == `TRFE_RATE_E3) ? 4 : 3;
        lp = 1'h0;
        par = 1'h0;
        z = 0;
        repeat (8) push(2'h0, 0);
        frm.idle();
        w = 0;
        // The first k line words are the cleared look-ahead slots, so they are skipped.
        while (got.size() < n + k && w < 200) begin
            @(posedge mclk);
            w++;
        end
        foreach (sent[i]) begin
            e.push_back(2'h0);
            if (sent[i] != 2'h0) begin
                lp = ~lp;
                e[i] = {lp, ~lp};
                par = ~par;
                z = 0;
            end else if (sr) begin
                z++;
                if (z == k) begin
                    if (!par) begin
                        lp = ~lp;
                        e[i-k+1] = {lp, ~lp};
                    end
                    e[i] = {lp, ~lp};
                    par = 1'h0;
                    z = 0;
                end
            end
        end
        `CHK(got.size() >= n + k, 1'b1)
        for (int i = 0; i < n; i++) `CHK(got[i + k], e[i])
    endtask

    // ------------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------------
    // Every rate code, with zero runs of three, four and six.
    task automatic t_rates();
        logic [23:0] pat;
        pat = 24'h8631C0;
        for (int r = 0; r < 4; r++) begin
            setup(1'h0, 1'h0, 1'h1, 2'(r));
            for (int i = 23; i >= 0; i--) push({pat[i], 1'h0}, 0);
            check_out(24);
        end
    endtask

    // Repeated polarities must leave alternating, and zero runs pass unchanged.
    task automatic t_dual();
        logic [1:0] d[12];
        d = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
        setup(1'h0, 1'h0, 1'h0, `TRFE_RATE_DS3);
        foreach (d[i]) push(d[i], 0);
        check_out(12);
    endtask

    // Host mode ignores the pin in both directions.
    task automatic t_host();
        setup(1'h1, 1'h0, 1'h1, `TRFE_RATE_E3);
        setup(1'h1, 1'h1, 1'h0, `TRFE_RATE_STS1);
        for (int i = 0; i < 10; i++) push({1'(i % 4 == 0), 1'h0}, 0);
        check_out(10);
    endtask

    // Stalled line fills the buffer; a word offered while full is lost.
    task automatic t_fill();
        setup(1'h0, 1'h0, 1'h1, `TRFE_RATE_DS3);
        line_ready <= 1'h0;
        for (int i = 0; i < 24; i++) begin
            // Ready lags the pins by the synchroniser, so the last push must land first.
            repeat (3) @(negedge mclk);
            if (!ready)
                break;
            push({1'(i % 3 == 0), 1'h0}, 2);
        end
        `CHK(ready, 1'h0)
        `CHK(sent.size() >= `TRFE_FIFO_DEPTH, 1'b1)
        frm.send(2'h2, 2);
        @(posedge mclk);
        line_ready <= 1'h1;
        check_out(sent.size());
    endtask

    initial begin
        #2000000;
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'h1;
        t_rates();
        t_dual();
        t_host();
        t_fill();
        end_of_test();
    end
endmodule
